// *** verilog/recording_mgmt_record_codec.sv ***
// recording-management record codec: register port, packer, zone and remap logic
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
module recording_mgmt_record_codec
    import recording_mgmt_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [11:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        dsv_cap_valid,
    input  wire logic        dsv_cap_linking,
    input  wire logic [4:0]  dsv_cap_frame,
    input  wire logic [10:0] dsv_cap_init,
    input  wire logic [2:0]  dsv_cap_state,
    input  wire logic        dsv_cap_tbit,
    input  wire logic        acc_req,
    input  wire logic        acc_ap_hit,
    input  wire logic [1:0]  acc_ap_idx,
    input  wire logic [31:0] acc_sector,
    output logic             acc_valid,
    output logic      [31:0] acc_out_sector,
    output logic             acc_redirected,
    output logic             append_grant,
    output logic             append_reject
);
    typedef struct packed {
        logic [1:0]         rec_sel;
        logic               incr;
        logic               auto_jump;
        logic               disc_closed;
        logic [1:0]         dsv_slot;
        logic [ST_W-1:0]    status;
        logic [3:0][15:0]   digital_sum_value;
        logic [63:0][7:0]   ws;
        logic [3:0][31:0]   ap;
        logic [8:0]         border_cnt;
        logic [15:0]        reserved_cnt;
        logic [2:0][15:0]   open_zone;
        logic [31:0]        inv_start;
        logic [31:0]        inv_jump;
        logic [3:0][31:0]   z1;
        logic [31:0]        rdata;
        logic               acc_valid;
        logic               acc_redir;
        logic [31:0]        acc_sector;
        logic               grant;
        logic               reject;
    } state_t;

    state_t      st_ff;
    state_t      nxt_st;
    logic [31:0] border_mem [0:503];
    logic [8:0]  brd_idx;
    logic [31:0] brd_word;
    logic        chk_layered;
    logic        chk_legal;
    logic        chk_zero;

    wire logic        reg_space = ~addr[11];
    wire logic [10:0] idx       = addr[10:0];

    // the jump address field carries no layer byte; kept out of the main process to avoid a loop
    assign chk_layered = (idx[10:2] == REG_Z1_BASE[10:2]) && (idx[1:0] != 2'd1);

    sector_field_check u_chk (
        .field     (wdata),
        .layered   (chk_layered),
        .legal     (chk_legal),
        .addr_zero (chk_zero)
    );

    // border-out entry behind the read window, guarded against underflow
    always_comb begin
        brd_idx = 9'd0;
        if (idx >= BORDER_FIRST) begin
            brd_idx = 9'((idx - BORDER_FIRST) >> 2);
        end
        brd_word = border_mem[brd_idx];
    end

    always_comb begin
        logic [ST_W-1:0]   set_st;
        logic [ST_W-1:0]   clr_st;
        logic [31:0]       rv;
        logic [7:0]        rb;
        logic [6:0]        soff;
        logic [6:0]        woff;
        logic [1:0]        slot;
        logic [15:0]       zone_num;
        logic [15:0]       zn;
        logic [2:0][15:0]  keep;
        logic              in_open;
        int                k;
        set_st   = '0;
        clr_st   = '0;
        rv       = 32'h00000000;
        rb       = 8'h00;
        soff     = idx[6:0];
        woff     = soff - WS_OFS_FIRST;
        slot     = idx[8:7];
        zn       = wdata[15:0];
        keep     = '0;
        in_open  = 1'b0;
        k        = 0;
        nxt_st   = st_ff;
        nxt_st.grant     = 1'b0;
        nxt_st.reject    = 1'b0;
        nxt_st.acc_valid = 1'b0;
        // the remainder zone only counts while the disc can still take data
        zone_num = st_ff.reserved_cnt + (st_ff.disc_closed ? 16'd0 : 16'd1); // see R15 see R16
        for (int i = 0; i < OPEN_MAX; i++) begin
            if (st_ff.open_zone[i] != 16'h0000 && st_ff.open_zone[i] == zn) begin
                in_open = 1'b1;
            end
        end

        // record packer, one byte per read
        case (st_ff.rec_sel)
            REC_DRIVE: begin
                if (idx < RESERVED_FROM) begin // see R7
                    if (soff >= WS_OFS_FIRST && soff <= WS_OFS_LAST) begin
                        rb = st_ff.ws[{slot, woff[3:0]}]; // see R6
                    end else if (soff == DSV_OFS_HI && st_ff.incr) begin
                        rb = st_ff.digital_sum_value[slot][15:8]; // see R1
                    end else if (soff == DSV_OFS_LO && st_ff.incr) begin
                        rb = st_ff.digital_sum_value[slot][7:0]; // see R1
                    end
                end
            end
            REC_USER: begin
                rb = 8'h00; // see R8
            end
            REC_BORDER: begin
                if (idx < AP_END) begin
                    rb = byte_of(st_ff.ap[idx[3:2]], idx[1:0]); // see R9
                end else if (idx >= BORDER_FIRST && brd_idx < st_ff.border_cnt) begin
                    rb = byte_of(brd_word, idx[1:0]); // see R12
                end
            end
            default: begin
                if (idx == 11'd0) begin
                    rb = zone_num[15:8]; // see R16
                end else if (idx == 11'd1) begin
                    rb = zone_num[7:0];
                end else if (idx >= ZN_OPEN_FIRST && idx <= ZN_OPEN_LAST) begin
                    rb = idx[0] ? st_ff.open_zone[idx[2:1] - 2'd1][7:0]
                                : st_ff.open_zone[idx[2:1] - 2'd1][15:8]; // see R17
                end else if (idx >= INV_START_OFS && idx <= INV_JUMP_END
                             && st_ff.auto_jump && !st_ff.disc_closed) begin
                    rb = (idx < INV_JUMP_OFS) ? byte_of(st_ff.inv_start, idx[1:0])
                                              : byte_of(st_ff.inv_jump, idx[1:0]); // see R18
                end else if (idx >= Z1_OFS_FIRST && idx <= Z1_OFS_LAST) begin
                    rb = byte_of(st_ff.z1[idx[3:2]], idx[1:0]); // see R19
                end
            end
        endcase

        // register read decode
        if (!reg_space) begin
            rv = {24'h000000, rb}; // see R22
        end else if (idx == REG_CTRL) begin
            rv = {25'h0, st_ff.dsv_slot, st_ff.disc_closed, st_ff.auto_jump,
                  st_ff.incr, st_ff.rec_sel};
        end else if (idx == REG_STATUS) begin
            rv = {{(32-ST_W){1'b0}}, st_ff.status};
        end else if (idx == REG_DSV) begin
            rv = {16'h0000, st_ff.digital_sum_value[st_ff.dsv_slot]};
        end else if (idx[10:2] == REG_AP_BASE[10:2]) begin
            rv = st_ff.ap[idx[1:0]];
        end else if (idx == REG_BORDER) begin
            rv = {23'h0, st_ff.border_cnt};
        end else if (idx == REG_ZONE_CMD) begin
            rv = {16'h0000, st_ff.reserved_cnt};
        end else if (idx == REG_INV_START) begin
            rv = st_ff.inv_start;
        end else if (idx == REG_INV_JUMP) begin
            rv = st_ff.inv_jump;
        end else if (idx == REG_JUMP_DEST) begin
            rv = {8'h00, ~st_ff.inv_jump[23:0]}; // see R20
        end else if (idx[10:2] == REG_Z1_BASE[10:2]) begin
            rv = st_ff.z1[idx[1:0]];
        end
        nxt_st.rdata = rd ? rv : 32'h00000000;

        // register write decode, also the parser for field checks
        if (wr && reg_space) begin
            if (idx == REG_CTRL) begin
                nxt_st.rec_sel     = wdata[CTRL_SEL_LSB +: 2];
                nxt_st.incr        = wdata[CTRL_INCR];
                nxt_st.auto_jump   = wdata[CTRL_AUTOJUMP];
                nxt_st.disc_closed = wdata[CTRL_CLOSED];
                nxt_st.dsv_slot    = wdata[CTRL_SLOT_LSB +: 2];
            end else if (idx == REG_STATUS) begin
                clr_st = wdata[ST_W-1:0];
            end else if (idx == REG_DSV) begin
                if (wdata[4:2] >= NEXT_STATE_MIN && wdata[4:2] <= NEXT_STATE_MAX) begin
                    nxt_st.digital_sum_value[st_ff.dsv_slot] = {wdata[15:1], 1'b0}; // see R3 see R4
                end else begin
                    set_st[ST_DSV_BAD] = 1'b1; // see R22
                end
            end else if (idx == REG_WS) begin
                nxt_st.ws[{wdata[13:12], wdata[11:8]}] = wdata[7:0]; // see R6
            end else if (idx[10:2] == REG_AP_BASE[10:2]) begin
                nxt_st.ap[idx[1:0]] = wdata;
            end else if (idx == REG_BORDER) begin
                if (st_ff.border_cnt < BORDER_MAX) begin
                    nxt_st.border_cnt = st_ff.border_cnt + 9'd1; // see R12
                end else begin
                    set_st[ST_BORDER_FUL] = 1'b1;
                end
            end else if (idx == REG_INV_START || idx == REG_INV_JUMP) begin
                if (chk_legal) begin
                    if (idx == REG_INV_START) begin
                        nxt_st.inv_start = wdata; // see R18
                    end else begin
                        nxt_st.inv_jump = wdata;
                    end
                end else begin
                    set_st[ST_TOPBYTE] = 1'b1; // see R18
                end
            end else if (idx[10:2] == REG_Z1_BASE[10:2]) begin
                if (chk_legal) begin
                    nxt_st.z1[idx[1:0]] = wdata; // see R19
                end else begin
                    set_st[chk_layered ? ST_LAYER_BAD : ST_TOPBYTE] = 1'b1; // see R21
                end
            end else if (idx == REG_ZONE_CMD) begin
                case (wdata[17:16])
                    ZCMD_RESERVE: begin
                        if (st_ff.disc_closed || st_ff.open_zone[OPEN_MAX-1] != 16'h0000) begin
                            set_st[ST_ZONE_REF] = 1'b1; // see R13
                            nxt_st.reject = 1'b1;
                        end else begin
                            nxt_st.reserved_cnt = st_ff.reserved_cnt + 16'd1;
                            for (int i = OPEN_MAX - 1; i >= 0; i--) begin
                                if (st_ff.open_zone[i] == 16'h0000) begin
                                    k = i;
                                end
                            end
                            nxt_st.open_zone[k] = st_ff.reserved_cnt + 16'd1; // see R17
                            nxt_st.grant = 1'b1;
                        end
                    end
                    ZCMD_CLOSE: begin
                        // keep the open list packed so first, second, third stay ordered
                        for (int i = 0; i < OPEN_MAX; i++) begin
                            if (st_ff.open_zone[i] != 16'h0000 && st_ff.open_zone[i] != zn) begin
                                keep[k] = st_ff.open_zone[i];
                                k = k + 1;
                            end
                        end
                        nxt_st.open_zone = keep; // see R17
                    end
                    ZCMD_APPEND: begin
                        if (in_open && !st_ff.disc_closed) begin
                            nxt_st.grant = 1'b1; // see R14
                        end else begin
                            nxt_st.reject = 1'b1; // see R14
                            set_st[ST_APPEND_REJ] = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // saved state only from the second sync frame of the linking sector
        if (dsv_cap_valid && dsv_cap_linking && dsv_cap_frame == SYNC_FRAME_SECOND) begin
            if (dsv_cap_state >= NEXT_STATE_MIN && dsv_cap_state <= NEXT_STATE_MAX) begin
                nxt_st.digital_sum_value[st_ff.dsv_slot] = {dsv_cap_init, dsv_cap_state,
                                              dsv_cap_tbit, 1'b0}; // see R5 see R2
            end else begin
                set_st[ST_DSV_BAD] = 1'b1;
            end
        end

        // anchor point lookup, one cycle
        if (acc_req) begin
            nxt_st.acc_valid = 1'b1;
            if (acc_ap_hit && st_ff.ap[acc_ap_idx] != 32'h00000000) begin
                nxt_st.acc_sector = st_ff.ap[acc_ap_idx]; // see R10
                nxt_st.acc_redir  = 1'b1;
            end else begin
                nxt_st.acc_sector = acc_sector; // see R11
                nxt_st.acc_redir  = 1'b0;
            end
        end

        // a new event beats a clear in the same cycle
        nxt_st.status = (st_ff.status & ~clr_st) | set_st;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // entry is written as the count advances; stale entries beyond count read as zero
    always_ff @(posedge clk_sys) begin
        if (wr && reg_space && idx == REG_BORDER && st_ff.border_cnt < BORDER_MAX) begin
            border_mem[st_ff.border_cnt] <= wdata; // see R12
        end
    end

    assign rdata          = st_ff.rdata;
    assign acc_valid      = st_ff.acc_valid;
    assign acc_out_sector = st_ff.acc_sector;
    assign acc_redirected = st_ff.acc_redir;
    assign append_grant   = st_ff.grant;
    assign append_reject  = st_ff.reject;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_REMAP_TAKEN: assert property (acc_req && acc_ap_hit && st_ff.ap[acc_ap_idx] != 0 // see R10
        |=> acc_valid && acc_redirected && acc_out_sector == $past(st_ff.ap[acc_ap_idx]))
        else $error("remap entry not applied");
    AST_REMAP_BYPASS: assert property (acc_req && !(acc_ap_hit && st_ff.ap[acc_ap_idx] != 0) // see R11
        |=> acc_valid && !acc_redirected && acc_out_sector == $past(acc_sector))
        else $error("access redirected without remap entry");
    AST_OPEN_LIMIT: assert property (wr && !addr[11] && addr[10:0] == REG_ZONE_CMD // see R13
        && wdata[17:16] == ZCMD_RESERVE && st_ff.open_zone[2] != 0
        |=> append_reject && !append_grant && $stable(st_ff.reserved_cnt) ##1 st_ff.status[ST_ZONE_REF])
        else $error("fourth open zone accepted");
    AST_APPEND_COMPLETE: assert property (wr && !addr[11] && addr[10:0] == REG_ZONE_CMD // see R14
        && wdata[17:16] == ZCMD_APPEND && wdata[15:0] != 0 && wdata[15:0] <= st_ff.reserved_cnt
        && st_ff.open_zone[0] != wdata[15:0] && st_ff.open_zone[1] != wdata[15:0]
        && st_ff.open_zone[2] != wdata[15:0] |=> append_reject && !append_grant)
        else $error("append to complete zone granted");
    AST_ZONE_COUNT: assert property (rd && addr == 12'h801 && st_ff.rec_sel == REC_ZONE // see R16
        && !(wr && !addr[11]) |=> rdata[7:0] == 8'($past(st_ff.reserved_cnt)
        + ($past(st_ff.disc_closed) ? 16'd0 : 16'd1)))
        else $error("zone number byte wrong");
    AST_RESERVED_ZERO: assert property (rd && addr[11] && addr[10:0] >= RESERVED_FROM // see R7
        && st_ff.rec_sel == REC_DRIVE |=> rdata == 32'h00000000)
        else $error("reserved drive-record byte not zero");
    AST_BORDER_EMPTY: assert property (rd && addr[11] && addr[10:0] >= AP_END // see R9
        && st_ff.rec_sel == REC_BORDER && st_ff.border_cnt == 0 |=> rdata == 32'h00000000)
        else $error("border record not zero before first border");
    AST_LAYER_REJECT: assert property (wr && !addr[11] && addr[10:0] == REG_Z1_BASE // see R21
        && wdata[31:24] != 8'h00 && wdata[31:24] != 8'hff
        |=> $stable(st_ff.z1[0]) && st_ff.status[ST_LAYER_BAD])
        else $error("illegal layer byte stored");
    AST_DSV_CAPTURE: assert property (dsv_cap_valid && dsv_cap_linking // see R5
        && dsv_cap_frame == SYNC_FRAME_SECOND && dsv_cap_state inside {[1:4]}
        |=> st_ff.digital_sum_value[$past(st_ff.dsv_slot)] == {$past(dsv_cap_init), $past(dsv_cap_state),
                                                  $past(dsv_cap_tbit), 1'b0})
        else $error("digital sum value not captured");
    AST_DSV_BIT0: assert property (st_ff.digital_sum_value[st_ff.dsv_slot][0] == 1'b0) // see R4
        else $error("digital sum value bit 0 set");

    COV_REMAP: cover property (acc_req && acc_ap_hit ##1 acc_redirected);
    COV_REFUSED: cover property (append_reject && st_ff.open_zone[2] != 0);
    COV_BORDER: cover property (st_ff.border_cnt == 9'd2 ##1 rd && addr[11]);
endmodule

// *** verilog/recording_mgmt_pkg.sv ***
// constants shared by the recording-management record codec
// Overview of operation
// R1 - each drive slot carries a 16-bit digital_sum_value; all zero means invalid
// R2 - first byte plus top three bits of second: 11-bit signed initial value
// R3 - bits 4..2 of second byte hold next code-word state, 1 to 4
// R4 - bit 1 holds last code-word bit, one space zero mark; bit 0 zero
// R5 - saved state comes from second sync frame start in linking sector
// R6 - layer-1 write strategy field holds the physical_format_info strategy code
// R7 - drive-slot record bytes 512 to 2047 are written as zeros
// R8 - unused user-data record is written entirely as zeros
// R9 - before any border closes, border record is zero beyond byte 15
// R10 - nonzero anchor_point remap entry redirects the access to its block
// R11 - zero anchor_point remap entry leaves the original block in use
// R12 - border-out starts stored from byte 32, at most 504, rest zero
// R13 - no more than three open reserved_zone entries at once
// R14 - append allowed to open zones, refused to complete zones
// R15 - unreserved_remainder_zone ceases to exist once disc is closed
// R16 - bytes 0..1 count unreserved, open and complete zones together
// R17 - bytes 2..7 hold first, second, third open zone numbers or zero
// R18 - unreserved zone start field has zero first byte; zero rest invalid; the codec checks only the first byte, addr_zero is left unused
// R19 - zone 1 entry sits at byte 48: start, jump, end, last recorded
// R20 - jump destination is the bitwise inverse of the stored jump address
// R21 - layer byte of sector fields must be 00 or ff, else rejected
// R22 - records are packed byte-serially and bad fields are flagged
package recording_mgmt_pkg;
    // register indices, byte address bit 11 clear
    localparam logic [10:0] REG_CTRL      = 11'h000;
    localparam logic [10:0] REG_STATUS    = 11'h001;
    localparam logic [10:0] REG_DSV       = 11'h002;
    localparam logic [10:0] REG_WS        = 11'h003;
    localparam logic [10:0] REG_AP_BASE   = 11'h004;
    localparam logic [10:0] REG_BORDER    = 11'h008;
    localparam logic [10:0] REG_ZONE_CMD  = 11'h009;
    localparam logic [10:0] REG_INV_START = 11'h00a;
    localparam logic [10:0] REG_INV_JUMP  = 11'h00b;
    localparam logic [10:0] REG_JUMP_DEST = 11'h00c;
    localparam logic [10:0] REG_Z1_BASE   = 11'h010;

    // control register fields
    localparam int CTRL_SEL_LSB  = 0;
    localparam int CTRL_INCR     = 2;
    localparam int CTRL_AUTOJUMP = 3;
    localparam int CTRL_CLOSED   = 4;
    localparam int CTRL_SLOT_LSB = 5;

    // status bits, sticky, write one to clear
    localparam int ST_LAYER_BAD  = 0;
    localparam int ST_TOPBYTE    = 1;
    localparam int ST_ZONE_REF   = 2;
    localparam int ST_APPEND_REJ = 3;
    localparam int ST_BORDER_FUL = 4;
    localparam int ST_DSV_BAD    = 5;
    localparam int ST_W          = 6;

    // record selectors
    localparam logic [1:0] REC_DRIVE  = 2'd0;
    localparam logic [1:0] REC_USER   = 2'd1;
    localparam logic [1:0] REC_BORDER = 2'd2;
    localparam logic [1:0] REC_ZONE   = 2'd3;

    // drive slot layout, offsets inside a 128-byte slot
    localparam logic [6:0]  WS_OFS_FIRST  = 7'd108;
    localparam logic [6:0]  WS_OFS_LAST   = 7'd123;
    localparam logic [6:0]  DSV_OFS_HI    = 7'd124;
    localparam logic [6:0]  DSV_OFS_LO    = 7'd125;
    localparam logic [10:0] RESERVED_FROM = 11'd512;

    // border record layout
    localparam logic [10:0] AP_END        = 11'd16;
    localparam logic [10:0] BORDER_FIRST  = 11'd32;
    localparam logic [8:0]  BORDER_MAX    = 9'd504;

    // zone record layout
    localparam logic [10:0] ZN_OPEN_FIRST = 11'd2;
    localparam logic [10:0] ZN_OPEN_LAST  = 11'd7;
    localparam logic [10:0] INV_START_OFS = 11'd16;
    localparam logic [10:0] INV_JUMP_OFS  = 11'd20;
    localparam logic [10:0] INV_JUMP_END  = 11'd23;
    localparam logic [10:0] Z1_OFS_FIRST  = 11'd48;
    localparam logic [10:0] Z1_OFS_LAST   = 11'd63;
    localparam int          OPEN_MAX      = 3;

    // zone commands in wdata[17:16]
    localparam logic [1:0] ZCMD_RESERVE = 2'd1;
    localparam logic [1:0] ZCMD_CLOSE   = 2'd2;
    localparam logic [1:0] ZCMD_APPEND  = 2'd3;

    // digital_sum_value coding
    localparam logic [4:0] SYNC_FRAME_SECOND = 5'd1;
    localparam logic [2:0] NEXT_STATE_MIN    = 3'd1;
    localparam logic [2:0] NEXT_STATE_MAX    = 3'd4;

    localparam logic [7:0] LAYER0_BYTE = 8'h00;
    localparam logic [7:0] LAYER1_BYTE = 8'hff;

    // big-endian byte k of a 4-byte field
    function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] k);
        case (k)
            2'd0: byte_of = w[31:24];
            2'd1: byte_of = w[23:16];
            2'd2: byte_of = w[15:8];
            default: byte_of = w[7:0];
        endcase
    endfunction
endpackage

// *** verilog/sector_field_check.sv ***
// layer byte and zero checks on a 4-byte sector field
`timescale 1ns/1ps
module sector_field_check
    import recording_mgmt_pkg::*;
(
    input  wire logic [31:0] field,
    input  wire logic        layered,
    output logic             legal,
    output logic             addr_zero
);
    always_comb begin
        // layered fields take 00 or ff, the others only 00
        if (layered) begin
            legal = (field[31:24] == LAYER0_BYTE) || (field[31:24] == LAYER1_BYTE); // see R21
        end else begin
            legal = (field[31:24] == LAYER0_BYTE); // see R18
        end
        addr_zero = (field[23:0] == 24'h000000);
    end
endmodule

// *** verification/drive_ctrl_model.sv ***
// drive controller model: encoder samples and access lookups
`timescale 1ns/1ps
module drive_ctrl_model (
    output logic        dsv_cap_valid,
    output logic        dsv_cap_linking,
    output logic [4:0]  dsv_cap_frame,
    output logic [10:0] dsv_cap_init,
    output logic [2:0]  dsv_cap_state,
    output logic        dsv_cap_tbit,
    output logic        acc_req,
    output logic        acc_ap_hit,
    output logic [1:0]  acc_ap_idx,
    output logic [31:0] acc_sector,
    input  wire logic   clk_sys
);
    initial begin
        {dsv_cap_valid, dsv_cap_linking, dsv_cap_frame, dsv_cap_init} = '0;
        {dsv_cap_state, dsv_cap_tbit, acc_req, acc_ap_hit, acc_ap_idx, acc_sector} = '0;
    end
    task automatic cap(input logic [4:0] f, input logic [10:0] i, input logic [2:0] s);
        @(posedge clk_sys);
        {dsv_cap_valid, dsv_cap_linking, dsv_cap_frame} <= {2'b11, f};
        {dsv_cap_init, dsv_cap_state, dsv_cap_tbit} <= {i, s, 1'b1};
        @(posedge clk_sys);
        dsv_cap_valid <= 1'b0;
        dsv_cap_init  <= ~i;
    endtask
    task automatic look(input logic [1:0] n, input logic [31:0] s);
        @(posedge clk_sys);
        {acc_req, acc_ap_hit, acc_ap_idx, acc_sector} <= {2'b11, n, s};
        @(posedge clk_sys);
        acc_req    <= 1'b0;
        acc_sector <= ~s;
    endtask
endmodule

// *** verification/recording_mgmt_record_codec_bench.sv ***
// self-checking bench for the record codec
`timescale 1ns/1ps
module recording_mgmt_record_codec_bench
    import recording_mgmt_pkg::*;
;
    logic clk_sys = 0, rst = 1, wr = 0, rd = 0;
    logic [11:0] addr = '0;
    logic [31:0] wdata = '0, rdata;
    logic dv, dl, dt, aq, ah, av, ar, ag, aj;
    logic [4:0] df;
    logic [10:0] di;
    logic [2:0] ds;
    logic [1:0] ai;
    logic [31:0] as, ao;
    int miscompares = 0, check_count = 0, cyc = 0;
    recording_mgmt_record_codec u_recording_mgmt_record_codec (.clk_sys(clk_sys), .rst(rst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .dsv_cap_valid(dv),
        .dsv_cap_linking(dl), .dsv_cap_frame(df), .dsv_cap_init(di), .dsv_cap_state(ds),
        .dsv_cap_tbit(dt), .acc_req(aq), .acc_ap_hit(ah), .acc_ap_idx(ai), .acc_sector(as),
        .acc_valid(av), .acc_out_sector(ao), .acc_redirected(ar), .append_grant(ag),
        .append_reject(aj));
    drive_ctrl_model u_drive_ctrl_model (.dsv_cap_valid(dv), .dsv_cap_linking(dl),
        .dsv_cap_frame(df), .dsv_cap_init(di), .dsv_cap_state(ds), .dsv_cap_tbit(dt),
        .acc_req(aq), .acc_ap_hit(ah), .acc_ap_idx(ai), .acc_sector(as), .clk_sys(clk_sys));
    initial forever #5 clk_sys = ~clk_sys;
    task automatic chk(input string n, input logic [31:0] v, input logic [31:0] e);
        check_count++;
        if (v !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, e, v);
        end
    endtask
    task automatic wrt(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk_sys);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        {rd, addr} <= {1'b1, a};
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 chk("rdata", rdata, e);
    endtask
    // zone command, then its one-cycle answer
    task automatic zc(input logic [31:0] d, input logic g);
        wrt({1'b0, REG_ZONE_CMD}, d);
        chk("grant", {31'b0, ag}, {31'b0, g});
        chk("reject", {31'b0, aj}, {31'b0, !g});
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rdc({1'b0, REG_STATUS}, 0);
        rdc(12'h0ff, 0);
        wrt({1'b0, REG_CTRL}, 32'h4);
        u_drive_ctrl_model.cap(5'd0, 11'h13a, 3'd2);
        rdc({1'b0, REG_DSV}, 0);
        u_drive_ctrl_model.cap(5'd1, 11'h2c5, 3'd3);
        rdc({1'b0, REG_DSV}, {16'h0, 11'h2c5, 3'd3, 2'b10});
        rdc(12'h87c, 32'h58);
        rdc(12'h87d, 32'hae);
        rdc(12'ha58, 0);
        wrt({1'b0, REG_WS}, 32'h1355);
        rdc(12'h8ef, 32'h55);
        wrt({1'b0, REG_DSV}, 32'h2);
        rdc({1'b0, REG_STATUS}, 32'h20);
        wrt({1'b0, REG_AP_BASE} + 12'd2, 32'h00012340);
        u_drive_ctrl_model.look(2'd2, 32'h700);
        #1 chk("redirect", {av, ar, ao[29:0]}, 32'hc0012340);
        u_drive_ctrl_model.look(2'd0, 32'h800);
        #1 chk("original", {av, ar, ao[29:0]}, 32'h80000800);
        wrt({1'b0, REG_CTRL}, 32'h5);
        rdc(12'h87c, 0);
        wrt({1'b0, REG_CTRL}, 32'h2);
        rdc(12'h80a, 32'h23);
        rdc(12'h814, 0);
        rdc(12'h828, 0);
        wrt({1'b0, REG_BORDER}, 32'h01abcdef);
        rdc(12'h821, 32'hab);
        for (int k = 0; k < 4; k++) zc(32'h10000, k < 3);
        wrt({1'b0, REG_CTRL}, 32'h3);
        rdc(12'h801, 32'h4);
        wrt({1'b0, REG_ZONE_CMD}, 32'h20001);
        zc(32'h30001, 1'b0);
        zc(32'h30002, 1'b1);
        rdc(12'h803, 32'h2);
        wrt({1'b0, REG_CTRL}, 32'hb);
        wrt({1'b0, REG_INV_JUMP}, 32'h00123456);
        rdc({1'b0, REG_JUMP_DEST}, 32'h00edcba9);
        rdc(12'h817, 32'h56);
        wrt({1'b0, REG_INV_START}, 32'h05000001);
        rdc({1'b0, REG_INV_START}, 0);
        wrt({1'b0, REG_CTRL}, 32'h13);
        rdc(12'h801, 32'h3);
        zc(32'h30002, 1'b0);
        wrt({1'b0, REG_STATUS}, 32'h3f);
        wrt({1'b0, REG_Z1_BASE}, 32'h12000000);
        rdc({1'b0, REG_STATUS}, 32'h1);
        wrt({1'b0, REG_Z1_BASE}, 32'hff000102);
        rdc(12'h830, 32'hff);
        give_verdict();
    end
endmodule
